// >>> bench/pad_model.sv
// pad model: resolves port s pin levels from drive, pulls and far side
// assumes the far side drives a pin only while its ext_en bit is high
`timescale 1ns/10ps
`default_nettype none
module pad_model (
   input  wire logic       clk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pull_up,
   input  wire logic [7:0] pull_down,
   input  wire logic [7:0] ext_value,
   input  wire logic [7:0] ext_en,
   output var  logic [7:0] level
);
   logic [7:0] last = 8'h00;
   // a line nobody holds shows the inverse, never a stale value
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) level[i] = pin_out[i];
         else if (ext_en[i]) level[i] = ext_value[i];
         else if (pull_up[i]) level[i] = 1'b1;
         else if (pull_down[i]) level[i] = 1'b0;
         else level[i] = ~last[i];
      end
   end
   always @(posedge clk) last <= level;
endmodule : pad_model
`default_nettype wire

// >>> bench/port_pad_config_and_routing_properties.sv
// checker: pad drive, pull, route and port m mux relations
// assumes binding into the top module; one clock, NRST low resets
`timescale 1ns/10ps
`default_nettype none
module port_pad_checks (
   input wire logic       CORE_CLK,
   input wire logic       NRST,
   input wire logic       IRQ,
   input wire logic [7:0] PORT_S_DIRECTION,
   input wire logic [7:0] PORT_S_OUT_VALUE,
   input wire logic [7:0] PORT_S_PIN_OUT,
   input wire logic [7:0] PORT_S_PIN_OE,
   input wire logic [7:0] PORT_S_PULL_UP_EN,
   input wire logic [7:0] PORT_S_PULL_DOWN_EN,
   input wire logic [7:0] EDGE_FLAG_SET,
   input wire logic [1:0] IIC_ROUTE,
   input wire logic [2:0] SPI_ROUTE,
   input wire logic [3:0] PORT_M_PIN_OUT,
   input wire logic [1:0] TIMER_COMPARE_EN,
   input wire logic [1:0] TIMER_COMPARE_OUT,
   input wire logic [1:0] PULSE_EN,
   input wire logic [1:0] PULSE_OUT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   a_pull_input_only: assert property (
      ((PORT_S_PULL_UP_EN | PORT_S_PULL_DOWN_EN) & $past(PORT_S_DIRECTION)) == 8'h00)
      else $error("pull active on an output pin");
   a_drive_level: assert property (
      (PORT_S_PIN_OE & (PORT_S_PIN_OUT ^ $past(PORT_S_OUT_VALUE))) == 8'h00)
      else $error("driven level differs from value");
   a_low_always_driven: assert property (
      ($past(PORT_S_DIRECTION & ~PORT_S_OUT_VALUE) & ~PORT_S_PIN_OE) == 8'h00)
      else $error("output low not driven");
   a_input_not_driven: assert property (
      (PORT_S_PIN_OE & ~$past(PORT_S_DIRECTION)) == 8'h00)
      else $error("input pin driven");
   a_iic_code_legal: assert property (IIC_ROUTE != 2'h1)
      else $error("two-wire route code 01 seen");
   a_spi_one_hot: assert property ($onehot0(SPI_ROUTE))
      else $error("four-wire route not one-hot");
   a_edge_one_cycle: assert property (
      (EDGE_FLAG_SET & $past(EDGE_FLAG_SET)) == 8'h00)
      else $error("edge pulse longer than a cycle");
   a_timer_wins: assert property ($past(TIMER_COMPARE_EN[0]) |->
      PORT_M_PIN_OUT[2] == $past(TIMER_COMPARE_OUT[0])) else $error("timer lost pin 2");
   a_pulse_wins: assert property ($past(PULSE_EN[1] && !TIMER_COMPARE_EN[1]) |->
      PORT_M_PIN_OUT[3] == $past(PULSE_OUT[1])) else $error("pulse lost pin 3");
   c_edge: cover property (EDGE_FLAG_SET != 8'h00);
   c_irq: cover property ($rose(IRQ));
   c_timer: cover property (TIMER_COMPARE_EN[0] && PULSE_EN[0]);
endmodule : port_pad_checks
bind port_pad_config_and_routing port_pad_checks checks (.*);
`default_nettype wire

// >>> bench/port_pad_config_and_routing_test.sv
// self-checking bench for the port pad configuration block
// assumes the pad model on port s; port m pins driven here
`timescale 1ns/10ps
`default_nettype none
module port_pad_config_and_routing_test;
   logic        CORE_CLK = 1'b0, NRST = 1'b0, BUS_WR = 1'b0, BUS_RD = 1'b0, IRQ;
   logic [11:0] BUS_ADDR = 12'h000;
   logic [7:0]  BUS_WDATA = 8'h00, PORT_S_DIRECTION = 8'h00, PORT_S_OUT_VALUE = 8'h00;
   logic [7:0]  ext = 8'h00, ext_en = 8'h00, BUS_RDATA, PORT_S_PIN_IN, PORT_S_PIN_OUT;
   logic [7:0]  PORT_S_PIN_OE, PORT_S_PULL_UP_EN, PORT_S_PULL_DOWN_EN, EDGE_FLAG_SET;
   logic [3:0]  PORT_M_PIN_IN = 4'h0, PORT_M_PIN_OUT, PORT_M_PIN_OE;
   logic [1:0]  TIMER_COMPARE_EN = 2'h0, TIMER_COMPARE_OUT = 2'h0, IIC_ROUTE;
   logic [1:0]  PULSE_EN = 2'h0, PULSE_OUT = 2'h0;
   logic [2:0]  SPI_ROUTE;
   int          miscompares = 0, comparisons = 0;
   port_pad_config_and_routing dut (.*);
   pad_model pads (.clk(CORE_CLK), .pin_out(PORT_S_PIN_OUT), .pin_oe(PORT_S_PIN_OE),
      .pull_up(PORT_S_PULL_UP_EN), .pull_down(PORT_S_PULL_DOWN_EN), .ext_value(ext),
      .ext_en(ext_en), .level(PORT_S_PIN_IN));
   always #25 CORE_CLK = ~CORE_CLK;
   // ------------------------------
   // bus and compare helpers
   // ------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      BUS_ADDR <= a;
      BUS_WDATA <= d;
      BUS_WR <= 1'b1;
      @(posedge CORE_CLK);
      BUS_WR <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] exp, input bit skip = 1'b0);
      @(posedge CORE_CLK);
      BUS_ADDR <= a;
      BUS_RD <= 1'b1;
      @(posedge CORE_CLK);
      BUS_RD <= 1'b0;
      @(negedge CORE_CLK);
      if (!skip) chk(BUS_RDATA, exp);
   endtask : rd
   task gap(input int n);
      repeat (n) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask : gap
   task tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // ------------------------------
   // scenarios
   // ------------------------------
   task t_reset;
      rd(port_cfg_pkg::OFS_PULL_ENABLE, 8'hff);
      rd(port_cfg_pkg::OFS_OPEN_DRAIN, 8'h00);
      rd(12'h2ff, 8'h00);
      chk(PORT_S_PULL_UP_EN, 8'hff);
      $display("test reset done");
   endtask : t_reset
   task t_pull;
      wr(port_cfg_pkg::OFS_PULL_POLARITY, 8'hf0);
      wr(port_cfg_pkg::OFS_PULL_ENABLE, 8'h3c);
      PORT_S_DIRECTION <= 8'h21;
      gap(1);
      chk(PORT_S_PULL_UP_EN, 8'h0c);
      chk(PORT_S_PULL_DOWN_EN, 8'h10);
      rd(port_cfg_pkg::OFS_PULL_POLARITY, 8'hf0);
      $display("test pull done");
   endtask : t_pull
   task t_open_drain;
      wr(port_cfg_pkg::OFS_OPEN_DRAIN, 8'h0f);
      PORT_S_DIRECTION <= 8'h33;
      PORT_S_OUT_VALUE <= 8'h55;
      gap(1);
      chk(PORT_S_PIN_OE, 8'h32);
      chk(PORT_S_PIN_IN & 8'h32, 8'h10);
      $display("test open drain done");
   endtask : t_open_drain
   task t_route;
      for (int i = 0; i < 4; i++) begin
         wr(port_cfg_pkg::OFS_ROUTE, 8'(i * 17));
         gap(1);
         chk({6'h00, IIC_ROUTE}, (i < 2) ? 8'h00 : 8'(i));
         chk({5'h00, SPI_ROUTE}, (i == 3) ? 8'h00 : 8'(1 << i));
      end
      $display("test route done");
   endtask : t_route
   task t_edge;
      wr(port_cfg_pkg::OFS_PULL_POLARITY, 8'h0f);
      wr(port_cfg_pkg::OFS_IRQ_MASK, 8'hff);
      PORT_S_DIRECTION <= 8'h00;
      ext_en <= 8'hff;
      gap(8);
      rd(port_cfg_pkg::OFS_IRQ_STATUS, 8'h00, 1'b1);
      @(posedge CORE_CLK);
      ext <= 8'hff;
      for (int k = 0; k < 10 && EDGE_FLAG_SET === 8'h00; k++) @(negedge CORE_CLK);
      chk(EDGE_FLAG_SET, 8'h0f);
      @(negedge CORE_CLK);
      chk({EDGE_FLAG_SET[6:0], IRQ}, 8'h01);
      rd(port_cfg_pkg::OFS_IRQ_STATUS, 8'h0f);
      rd(port_cfg_pkg::OFS_IRQ_STATUS, 8'h00);
      wr(port_cfg_pkg::OFS_IRQ_MASK, 8'h00);
      ext <= 8'h00;
      gap(8);
      chk({7'h00, IRQ}, 8'h00);
      rd(port_cfg_pkg::OFS_IRQ_STATUS, 8'hf0);
      $display("test edge done");
   endtask : t_edge
   task t_port_m;
      wr(port_cfg_pkg::OFS_PORT_M_DIR, 8'h0f);
      wr(port_cfg_pkg::OFS_PORT_M_DATA, 8'hfa);
      gap(1);
      chk({PORT_M_PIN_OE, PORT_M_PIN_OUT}, 8'hfa);
      rd(port_cfg_pkg::OFS_PORT_M_DATA, 8'h0a);
      wr(port_cfg_pkg::OFS_PORT_M_DIR, 8'h00);
      PORT_M_PIN_IN <= 4'h5;
      gap(6);
      rd(port_cfg_pkg::OFS_PORT_M_DATA, 8'h05);
      wr(port_cfg_pkg::OFS_PORT_M_DIR, 8'h0f);
      TIMER_COMPARE_EN <= 2'h1;
      TIMER_COMPARE_OUT <= 2'h1;
      PULSE_EN <= 2'h3;
      gap(1);
      chk({4'h0, PORT_M_PIN_OUT}, 8'h06);
      @(posedge CORE_CLK);
      TIMER_COMPARE_EN <= 2'h0;
      PULSE_EN <= 2'h0;
      NRST <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      NRST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      wr(port_cfg_pkg::OFS_PORT_M_DIR, 8'h0f);
      rd(port_cfg_pkg::OFS_PORT_M_DATA, 8'h0a);
      $display("test port m done");
   endtask : t_port_m
   initial begin
      repeat (2) @(posedge CORE_CLK);
      NRST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      t_reset();
      t_pull();
      t_open_drain();
      t_route();
      t_edge();
      t_port_m();
      tally_and_finish();
   end
   // whole run is about a hundred cycles
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule : port_pad_config_and_routing_test
`default_nettype wire

// >>> verilog/port_cfg_pkg.sv
// shared constants and carriers for the port pad configuration block
// assumes a plain strobe register port with byte-wide data
package port_cfg_pkg;
   localparam logic [11:0] OFS_PORT_M_DATA   = 12'h250;
   localparam logic [11:0] OFS_PULL_ENABLE   = 12'h240;
   localparam logic [11:0] OFS_PULL_POLARITY = 12'h241;
   localparam logic [11:0] OFS_OPEN_DRAIN    = 12'h242;
   localparam logic [11:0] OFS_ROUTE         = 12'h243;
   localparam logic [11:0] OFS_IRQ_STATUS    = 12'h244;
   localparam logic [11:0] OFS_IRQ_MASK      = 12'h245;
   localparam logic [11:0] OFS_PORT_M_DIR    = 12'h246;
   localparam logic [7:0]  RST_PULL_ENABLE   = 8'hff;
   localparam logic [7:0]  RST_PULL_POLARITY = 8'h00;
   localparam logic [7:0]  RST_OPEN_DRAIN    = 8'h00;
   localparam logic [7:0]  RST_ROUTE         = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK      = 8'h00;
   localparam logic [3:0]  RST_PORT_M_DIR    = 4'h0;
   // cycles after reset until the synchronised level and its previous copy are real
   localparam logic [2:0]  EDGE_SETTLE_CYCLES = 3'h5;
   localparam int          ROUTE_IIC_LSB     = 0;
   localparam int          ROUTE_SPI_LSB     = 4;
   localparam logic [1:0]  IIC_ALT_B         = 2'h2;
   localparam logic [1:0]  IIC_ALT_C         = 2'h3;
   localparam logic [1:0]  SPI_DEFAULT       = 2'h0;
   localparam logic [1:0]  SPI_ALT_B         = 2'h1;
   localparam logic [1:0]  SPI_ALT_C         = 2'h2;
   localparam logic [1:0]  SPI_RESERVED      = 2'h3;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;

   typedef struct packed {
      logic [1:0] iic;
      logic [1:0] spi;
   } route_sel_type;
endpackage : port_cfg_pkg

// >>> verilog/port_pad_config_and_routing.sv
// pad configuration for port s and data/mux logic for port m
// assumes pins are sampled asynchronously and a byte-wide strobe bus master
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - pull only active while pin is input
// - all pulls enabled after reset
// - polarity one: rising edge, pull down
// - polarity zero: falling edge, pull up
// - open-drain drives low only, else push-pull
// - open-drain ignored on input pins
// - bits 1:0 place two-wire serial pins
// - bits 5:4 place four-wire serial pins
// - configuration registers writable any time
// - general output drives data bit
// - read stored bit if output, else pin
// - timer compare overrides pulse and gpio
// - pulse channel overrides gpio
// - upper bits read zero, data unaffected
// - pin read-back lags up to five cycles
module port_pad_config_and_routing (
   input  wire logic        CORE_CLK,
   input  wire logic        NRST,
   input  wire logic [11:0] BUS_ADDR,
   input  wire logic [7:0]  BUS_WDATA,
   input  wire logic        BUS_WR,
   input  wire logic        BUS_RD,
   output var  logic [7:0]  BUS_RDATA,
   output var  logic        IRQ,
   input  wire logic [7:0]  PORT_S_DIRECTION,
   input  wire logic [7:0]  PORT_S_OUT_VALUE,
   input  wire logic [7:0]  PORT_S_PIN_IN,
   output var  logic [7:0]  PORT_S_PIN_OUT,
   output var  logic [7:0]  PORT_S_PIN_OE,
   output var  logic [7:0]  PORT_S_PULL_UP_EN,
   output var  logic [7:0]  PORT_S_PULL_DOWN_EN,
   output var  logic [7:0]  EDGE_FLAG_SET,
   output var  logic [1:0]  IIC_ROUTE,
   output var  logic [2:0]  SPI_ROUTE,
   input  wire logic [3:0]  PORT_M_PIN_IN,
   output var  logic [3:0]  PORT_M_PIN_OUT,
   output var  logic [3:0]  PORT_M_PIN_OE,
   input  wire logic [1:0]  TIMER_COMPARE_EN,
   input  wire logic [1:0]  TIMER_COMPARE_OUT,
   input  wire logic [1:0]  PULSE_EN,
   input  wire logic [1:0]  PULSE_OUT
);

   // --------------------------------------------------
   // reset release
   // --------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // --------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------
   // three stages; a change counts when stages two and three agree
   logic [7:0] s_meta, s_mid, s_late, s_level, s_level_prev;
   logic [3:0] m_meta, m_mid, m_late, m_level;
   logic [7:0] next_s_level;
   logic [3:0] next_m_level;

   always_comb begin
      next_s_level = s_level;
      next_m_level = m_level;
      for (int i = 0; i < 8; i++) begin
         if (s_mid[i] == s_late[i]) begin
            next_s_level[i] = s_late[i];
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (m_mid[i] == m_late[i]) begin
            next_m_level[i] = m_late[i];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_meta       <= 8'h00;
         s_mid        <= 8'h00;
         s_late       <= 8'h00;
         s_level      <= 8'h00;
         s_level_prev <= 8'h00;
         m_meta       <= 4'h0;
         m_mid        <= 4'h0;
         m_late       <= 4'h0;
         m_level      <= 4'h0;
      end else begin
         s_meta       <= PORT_S_PIN_IN;
         s_mid        <= s_meta;
         s_late       <= s_mid;
         s_level      <= next_s_level;
         s_level_prev <= s_level;
         m_meta       <= PORT_M_PIN_IN;
         m_mid        <= m_meta;
         m_late       <= m_mid;
         m_level      <= next_m_level;
      end
   end

   // --------------------------------------------------
   // edge qualification after reset
   // --------------------------------------------------
   // the synchronisers come out of reset at zero; a pin that idles high
   // would otherwise look like a rising edge once its level arrives.
   // edges are only reported once level and previous level both hold
   // real pin samples, at the cost of a few blind cycles after reset.
   logic [2:0] settle_count;
   logic [2:0] next_settle_count;
   logic       edges_armed;

   always_comb begin
      next_settle_count = settle_count;
      if (settle_count != port_cfg_pkg::EDGE_SETTLE_CYCLES) begin
         next_settle_count = settle_count + 3'h1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         settle_count <= 3'h0;
      end else begin
         settle_count <= next_settle_count;
      end
   end

   assign edges_armed = (settle_count == port_cfg_pkg::EDGE_SETTLE_CYCLES);

   // --------------------------------------------------
   // registers
   // --------------------------------------------------
   logic [7:0] pull_enable_bits, pull_polarity_bits, open_drain_bits;
   logic [7:0] serial_route_select, irq_status, irq_mask;
   logic [3:0] port_m_data_bits, port_m_dir;
   logic [7:0] next_pull_enable, next_pull_polarity, next_open_drain;
   logic [7:0] next_route, next_irq_status, next_irq_mask;
   logic [3:0] next_port_m_data, next_port_m_dir;
   logic [7:0] next_rdata;
   logic [7:0] edge_hit;
   logic [3:0] port_m_read;
   port_cfg_pkg::bus_req_type req;

   assign req = '{addr: BUS_ADDR, wdata: BUS_WDATA, wr: BUS_WR, rd: BUS_RD};

   // edge by polarity: one catches rising, zero catches falling
   assign edge_hit = {8{edges_armed}}
                   & ((pull_polarity_bits & s_level & ~s_level_prev)
                   | (~pull_polarity_bits & ~s_level & s_level_prev));

   // output pins read back the stored bit, inputs the synced pin
   assign port_m_read = (port_m_dir & port_m_data_bits) | (~port_m_dir & m_level);

   always_comb begin
      next_pull_enable   = pull_enable_bits;
      next_pull_polarity = pull_polarity_bits;
      next_open_drain    = open_drain_bits;
      next_route         = serial_route_select;
      next_irq_mask      = irq_mask;
      next_port_m_data   = port_m_data_bits;
      next_port_m_dir    = port_m_dir;
      next_irq_status    = irq_status;
      next_rdata         = 8'h00;
      if (req.wr) begin
         unique case (req.addr)
            port_cfg_pkg::OFS_PULL_ENABLE:   next_pull_enable   = req.wdata;
            port_cfg_pkg::OFS_PULL_POLARITY: next_pull_polarity = req.wdata;
            port_cfg_pkg::OFS_OPEN_DRAIN:    next_open_drain    = req.wdata;
            port_cfg_pkg::OFS_ROUTE:         next_route         = req.wdata;
            port_cfg_pkg::OFS_IRQ_MASK:      next_irq_mask      = req.wdata;
            port_cfg_pkg::OFS_PORT_M_DATA:   next_port_m_data   = req.wdata[3:0];
            port_cfg_pkg::OFS_PORT_M_DIR:    next_port_m_dir    = req.wdata[3:0];
            default: ;
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            port_cfg_pkg::OFS_PULL_ENABLE:   next_rdata = pull_enable_bits;
            port_cfg_pkg::OFS_PULL_POLARITY: next_rdata = pull_polarity_bits;
            port_cfg_pkg::OFS_OPEN_DRAIN:    next_rdata = open_drain_bits;
            port_cfg_pkg::OFS_ROUTE:         next_rdata = serial_route_select;
            port_cfg_pkg::OFS_IRQ_MASK:      next_rdata = irq_mask;
            port_cfg_pkg::OFS_IRQ_STATUS:    next_rdata = irq_status;
            port_cfg_pkg::OFS_PORT_M_DATA:   next_rdata = {4'h0, port_m_read};
            port_cfg_pkg::OFS_PORT_M_DIR:    next_rdata = {4'h0, port_m_dir};
            default:                         next_rdata = 8'h00;
         endcase
         if (req.addr == port_cfg_pkg::OFS_IRQ_STATUS) begin
            next_irq_status = 8'h00;
         end
      end
      // a new edge in the clearing cycle survives
      next_irq_status = next_irq_status | edge_hit;
   end

   // data bits are not reset so they keep their value through reset
   always_ff @(posedge CORE_CLK) begin
      port_m_data_bits <= next_port_m_data;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pull_enable_bits    <= port_cfg_pkg::RST_PULL_ENABLE;
         pull_polarity_bits  <= port_cfg_pkg::RST_PULL_POLARITY;
         open_drain_bits     <= port_cfg_pkg::RST_OPEN_DRAIN;
         serial_route_select <= port_cfg_pkg::RST_ROUTE;
         irq_mask            <= port_cfg_pkg::RST_IRQ_MASK;
         port_m_dir          <= port_cfg_pkg::RST_PORT_M_DIR;
         irq_status          <= 8'h00;
         BUS_RDATA           <= 8'h00;
      end else begin
         pull_enable_bits    <= next_pull_enable;
         pull_polarity_bits  <= next_pull_polarity;
         open_drain_bits     <= next_open_drain;
         serial_route_select <= next_route;
         irq_mask            <= next_irq_mask;
         port_m_dir          <= next_port_m_dir;
         irq_status          <= next_irq_status;
         BUS_RDATA           <= next_rdata;
      end
   end

   // --------------------------------------------------
   // pad and mux outputs
   // --------------------------------------------------
   port_cfg_pkg::route_sel_type route;
   logic [7:0] next_s_out, next_s_oe, next_pu, next_pd, next_flag_set;
   logic [3:0] next_m_out, next_m_oe;
   logic [1:0] next_iic_route;
   logic [2:0] next_spi_route;
   logic [1:0] spi_code;
   logic       m_drive;
   logic       m_value;

   assign route.iic = serial_route_select[port_cfg_pkg::ROUTE_IIC_LSB +: 2];
   assign route.spi = serial_route_select[port_cfg_pkg::ROUTE_SPI_LSB +: 2];

   always_comb begin
      spi_code = route.spi;
      // one-hot port select; reserved code places the four-wire pins nowhere
      next_spi_route = 3'h0;
      unique case (spi_code)
         port_cfg_pkg::SPI_DEFAULT:  next_spi_route = 3'h1;
         port_cfg_pkg::SPI_ALT_B:    next_spi_route = 3'h2;
         port_cfg_pkg::SPI_ALT_C:    next_spi_route = 3'h4;
         port_cfg_pkg::SPI_RESERVED: next_spi_route = 3'h0;
      endcase
      // codes 00 and 01 both keep the default pair
      next_iic_route = route.iic;
      if (route.iic != port_cfg_pkg::IIC_ALT_B && route.iic != port_cfg_pkg::IIC_ALT_C) begin
         next_iic_route = 2'h0;
      end
      for (int i = 0; i < 8; i++) begin
         // open-drain only acts on outputs; a one releases the pin
         next_s_out[i] = open_drain_bits[i] ? 1'b0 : PORT_S_OUT_VALUE[i];
         next_s_oe[i]  = PORT_S_DIRECTION[i] &
                         (~open_drain_bits[i] | ~PORT_S_OUT_VALUE[i]);
         next_pu[i]    = ~PORT_S_DIRECTION[i] & pull_enable_bits[i]
                         & ~pull_polarity_bits[i];
         next_pd[i]    = ~PORT_S_DIRECTION[i] & pull_enable_bits[i]
                         & pull_polarity_bits[i];
      end
      next_flag_set = edge_hit;
      next_m_out = port_m_data_bits;
      next_m_oe  = port_m_dir;
      for (int i = 0; i < 2; i++) begin
         m_drive = 1'b0;
         m_value = 1'b0;
         if (TIMER_COMPARE_EN[i]) begin
            m_drive = 1'b1;
            m_value = TIMER_COMPARE_OUT[i];
         end else if (PULSE_EN[i]) begin
            m_drive = 1'b1;
            m_value = PULSE_OUT[i];
         end
         if (m_drive) begin
            next_m_out[i + 2] = m_value;
            next_m_oe[i + 2]  = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PORT_S_PIN_OUT      <= 8'h00;
         PORT_S_PIN_OE       <= 8'h00;
         PORT_S_PULL_UP_EN   <= 8'h00;
         PORT_S_PULL_DOWN_EN <= 8'h00;
         EDGE_FLAG_SET       <= 8'h00;
         IIC_ROUTE           <= 2'h0;
         SPI_ROUTE           <= 3'h0;
         PORT_M_PIN_OUT      <= 4'h0;
         PORT_M_PIN_OE       <= 4'h0;
         IRQ                 <= 1'b0;
      end else begin
         PORT_S_PIN_OUT      <= next_s_out;
         PORT_S_PIN_OE       <= next_s_oe;
         PORT_S_PULL_UP_EN   <= next_pu;
         PORT_S_PULL_DOWN_EN <= next_pd;
         EDGE_FLAG_SET       <= next_flag_set;
         IIC_ROUTE           <= next_iic_route;
         SPI_ROUTE           <= next_spi_route;
         PORT_M_PIN_OUT      <= next_m_out;
         PORT_M_PIN_OE       <= next_m_oe;
         IRQ                 <= |(next_irq_status & irq_mask);
      end
   end

endmodule : port_pad_config_and_routing

`default_nettype wire
